// ---- hw/ieru_cfg.svh ----
// Constants for the interrupt entry and return unit.
// Assumes inclusion by bare name from the design files.
`ifndef IERU_CFG_SVH
`define IERU_CFG_SVH

`define IERU_PSW_RESET      32'h00000020
`define IERU_NP_BIT         7
`define IERU_EP_BIT         6
`define IERU_ID_BIT         5
`define IERU_NMI_CAUSE      16'h0010
`define IERU_WDT_NMI_MODE   2'h1
`define IERU_NUM_SRC        52
`define IERU_NMI_HANDLER    32'h00000010
`define IERU_WDT_HANDLER    32'h00000020
`define IERU_IRQ_BASE       32'h00000080
`define IERU_IRQ_CAUSE_BASE 16'h0080

`endif

// ---- hw/ieru_pkg.sv ----
// Types for the interrupt entry and return unit.
// Assumes ieru_cfg.svh is compiled with it.
`include "ieru_cfg.svh"
package ieru_pkg;
	typedef logic [5:0] ieru_src_type;
	typedef logic [2:0] ieru_prio_type;
	typedef enum logic [3:0] {
		IERU_ST_RUN = 4'h1,
		IERU_ST_NMI = 4'h2,
		IERU_ST_WDT = 4'h4,
		IERU_ST_IRQ = 4'h8
	} ieru_state_type;
endpackage

// ---- hw/ieru_arb_if.sv ----
// Carries the winning maskable request between arbiter and core logic.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface ieru_arb_if;
	logic                   valid;
	ieru_pkg::ieru_src_type src;
	ieru_pkg::ieru_prio_type prio;
	modport arb (output valid, output src, output prio);
	modport core (input valid, input src, input prio);
endinterface
`default_nettype wire

// ---- hw/ieru_edge.sv ----
// NMI pin synchroniser and edge selector.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ieru_cfg.svh"
module ieru_edge (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset_n,
	// Pin and edge choice
	input  wire logic nmi_pin,
	input  wire logic nmi_rise_sel,
	input  wire logic nmi_fall_sel,
	// Detected edge
	output logic      nmi_edge
);
	import ieru_pkg::*;
	logic [2:0] sync_reg;
	logic [2:0] sync_next;

	always_comb begin
		sync_next = {sync_reg[1:0], nmi_pin};
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_reg <= 3'h0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	// Only stages 1 and 2 feed the compare
	assign nmi_edge = (nmi_rise_sel & sync_reg[1] & ~sync_reg[2]) |
		(nmi_fall_sel & ~sync_reg[1] & sync_reg[2]);
endmodule
`default_nettype wire

// ---- hw/ieru_arb.sv ----
// Maskable request arbiter over level programmable and default priority.
// Assumes requests are same-clock levels from the controller.
`timescale 1ns/1ps
`default_nettype none
`include "ieru_cfg.svh"
module ieru_arb (
	// Requests and per-source setup
	input  wire logic [`IERU_NUM_SRC-1:0]   irq_req,
	input  wire logic [`IERU_NUM_SRC-1:0]   irq_mask,
	input  wire logic [3*`IERU_NUM_SRC-1:0] irq_prio,
	// Winner
	ieru_arb_if.arb                         win
);
	import ieru_pkg::*;
	logic          found;
	ieru_src_type  best_src;
	ieru_prio_type best_prio;

	always_comb begin
		found     = 1'b0;
		best_src  = 6'h00;
		best_prio = 3'h7;
		// Scan from highest index so index 0 wins ties
		for (int i = `IERU_NUM_SRC - 1; i >= 0; i--) begin
			if (irq_req[i] && !irq_mask[i]) begin
				if (!found || irq_prio[3*i +: 3] <= best_prio) begin
					found     = 1'b1;
					best_src  = 6'(i);
					best_prio = irq_prio[3*i +: 3];
				end
			end
		end
	end

	assign win.valid = found;
	assign win.src   = best_src;
	assign win.prio  = best_prio;
endmodule
`default_nettype wire

// ---- hw/ieru_core.sv ----
// Interrupt entry and return unit: NMI, watchdog NMI and maskable entry,
// status word handling and return selection.
// Assumes the pipeline pulses op strobes one cycle and follows pc_load.
`timescale 1ns/1ps
`default_nettype none
`include "ieru_cfg.svh"
module ieru_core (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	// Non-maskable sources
	input  wire logic                       nmi_pin,
	input  wire logic                       nmi_rise_sel,
	input  wire logic                       nmi_fall_sel,
	input  wire logic                       watchdog_nmi_req,
	input  wire logic [1:0]                 watchdog_mode_field,
	// Maskable sources
	input  wire logic [`IERU_NUM_SRC-1:0]   irq_req,
	input  wire logic [`IERU_NUM_SRC-1:0]   irq_mask,
	input  wire logic [3*`IERU_NUM_SRC-1:0] irq_prio,
	// Pipeline side
	input  wire logic [31:0]                restored_pc,
	input  wire logic                       return_from_irq_op,
	input  wire logic                       irq_unmask_op,
	input  wire logic                       irq_mask_op,
	input  wire logic                       sysreg_load_op,
	input  wire logic [2:0]                 sysreg_sel,
	input  wire logic [31:0]                sysreg_wdata,
	// Control transfer
	output logic                            pc_load,
	output logic [31:0]                     pc_value,
	output logic                            irq_ack,
	output logic [5:0]                      irq_ack_src,
	// Visible state
	output logic [31:0]                     cpu_status_word,
	output logic [31:0]                     nmi_saved_pc,
	output logic [31:0]                     nmi_saved_status,
	output logic [31:0]                     irq_saved_pc,
	output logic [31:0]                     irq_saved_status,
	output logic [31:0]                     cause_code_reg,
	output logic [2:0]                      service_level,
	output ieru_pkg::ieru_state_type        service_state
);
	import ieru_pkg::*;

	// System register selects for sysreg_load_op
	localparam logic [2:0] SEL_PSW   = 3'h0;
	localparam logic [2:0] SEL_EPC   = 3'h1;
	localparam logic [2:0] SEL_EPSW  = 3'h2;
	localparam logic [2:0] SEL_FPC   = 3'h3;
	localparam logic [2:0] SEL_FPSW  = 3'h4;

	ieru_arb_if win ();
	logic nmi_edge;

	ieru_edge u_edge (
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.nmi_pin      (nmi_pin),
		.nmi_rise_sel (nmi_rise_sel),
		.nmi_fall_sel (nmi_fall_sel),
		.nmi_edge     (nmi_edge)
	);

	ieru_arb u_arb (
		.irq_req  (irq_req),
		.irq_mask (irq_mask),
		.irq_prio (irq_prio),
		.win      (win)
	);

	// Watchdog input crosses from its own logic; synchronise anyway
	logic [1:0] wdt_sync_reg;
	logic       wdt_prev_reg;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wdt_sync_reg <= 2'h0;
			wdt_prev_reg <= 1'b0;
		end else begin
			wdt_sync_reg <= {wdt_sync_reg[0], watchdog_nmi_req};
			wdt_prev_reg <= wdt_sync_reg[1];
		end
	end

	logic wdt_event;
	assign wdt_event = wdt_sync_reg[1] & ~wdt_prev_reg &
		(watchdog_mode_field == `IERU_WDT_NMI_MODE);

	// State
	ieru_state_type state_reg,  state_next;
	logic [31:0]    psw_reg,    psw_next;
	logic [31:0]    fpc_reg,    fpc_next;
	logic [31:0]    fpsw_reg,   fpsw_next;
	logic [31:0]    epc_reg,    epc_next;
	logic [31:0]    epsw_reg,   epsw_next;
	logic [31:0]    ecr_reg,    ecr_next;
	logic           nmi_pend_reg, nmi_pend_next;
	logic           wdt_pend_reg, wdt_pend_next;
	logic [2:0]     lvl_reg,    lvl_next;
	logic           nested_reg, nested_next;
	logic           pcl_reg,    pcl_next;
	logic [31:0]    pcv_reg,    pcv_next;
	logic           ack_reg,    ack_next;
	logic [5:0]     ack_src_reg, ack_src_next;

	logic np;
	logic id;
	logic ep;
	logic take_wdt;
	logic take_nmi;
	logic take_irq;
	logic in_pin_nmi;

	assign np = psw_reg[`IERU_NP_BIT];
	assign id = psw_reg[`IERU_ID_BIT];
	assign ep = psw_reg[`IERU_EP_BIT];
	assign in_pin_nmi = (state_reg == IERU_ST_NMI);

	always_comb begin
		state_next    = state_reg;
		psw_next      = psw_reg;
		fpc_next      = fpc_reg;
		fpsw_next     = fpsw_reg;
		epc_next      = epc_reg;
		epsw_next     = epsw_reg;
		ecr_next      = ecr_reg;
		lvl_next      = lvl_reg;
		nested_next   = nested_reg;
		pcl_next      = 1'b0;
		pcv_next      = pcv_reg;
		ack_next      = 1'b0;
		ack_src_next  = ack_src_reg;
		// Pending latches; new events set, but a pin edge with a watchdog event is dropped; taking clears
		nmi_pend_next = nmi_pend_reg | (nmi_edge & ~wdt_event);
		wdt_pend_next = wdt_pend_reg | wdt_event;

		// Software writes first so hardware entry overrides same cycle
		if (sysreg_load_op) begin
			case (sysreg_sel)
				SEL_PSW:  psw_next  = sysreg_wdata;
				SEL_EPC:  epc_next  = sysreg_wdata;
				SEL_EPSW: epsw_next = sysreg_wdata;
				SEL_FPC:  fpc_next  = sysreg_wdata;
				SEL_FPSW: fpsw_next = sysreg_wdata;
				default:  psw_next  = psw_reg;
			endcase
		end
		// Level compare only inside a maskable handler
		if (irq_unmask_op) begin
			psw_next[`IERU_ID_BIT] = 1'b0;
			nested_next = (state_reg == IERU_ST_IRQ);
		end
		if (irq_mask_op) begin
			psw_next[`IERU_ID_BIT] = 1'b1;
		end

		// Return path; pending NMIs wait until this clears state
		if (return_from_irq_op && !ep) begin
			pcl_next = 1'b1;
			if (np) begin
				pcv_next   = fpc_reg;
				psw_next   = fpsw_reg;
				state_next = IERU_ST_RUN;
			end else begin
				pcv_next   = epc_reg;
				psw_next   = epsw_reg;
				state_next = IERU_ST_RUN;
				nested_next = 1'b0;
			end
		end

		// Acceptance; watchdog preempts only when active flag cleared
		take_wdt = wdt_pend_reg && !return_from_irq_op &&
			!np;
		take_nmi = !take_wdt && nmi_pend_reg && !in_pin_nmi &&
			!np && !return_from_irq_op;
		// Maskable only when both flags clear and, when nested, level strictly higher
		take_irq = !take_wdt && !take_nmi && win.valid && !np && !id &&
			!return_from_irq_op &&
			(!nested_reg || win.prio < lvl_reg);

		if (take_wdt || take_nmi) begin
			fpc_next  = restored_pc;
			fpsw_next = psw_reg;
			ecr_next[31:16] = `IERU_NMI_CAUSE;
			psw_next[`IERU_NP_BIT] = 1'b1;
			psw_next[`IERU_ID_BIT] = 1'b1;
			psw_next[`IERU_EP_BIT] = 1'b0;
			pcl_next  = 1'b1;
			if (take_wdt) begin
				wdt_pend_next = wdt_event;
				// No return expected from this state
				pcv_next   = `IERU_WDT_HANDLER;
				state_next = IERU_ST_WDT;
			end else begin
				nmi_pend_next = nmi_edge & ~wdt_event;
				pcv_next   = `IERU_NMI_HANDLER;
				state_next = IERU_ST_NMI;
			end
		end else if (take_irq) begin
			epc_next  = restored_pc;
			epsw_next = psw_reg;
			ecr_next[15:0] = `IERU_IRQ_CAUSE_BASE + {6'h00, win.src, 4'h0};
			psw_next[`IERU_ID_BIT] = 1'b1;
			psw_next[`IERU_EP_BIT] = 1'b0;
			lvl_next     = win.prio;
			nested_next  = 1'b0;
			pcl_next     = 1'b1;
			pcv_next     = `IERU_IRQ_BASE + {22'h0, win.src, 4'h0};
			ack_next     = 1'b1;
			ack_src_next = win.src;
			state_next   = IERU_ST_IRQ;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg    <= IERU_ST_RUN;
			psw_reg      <= `IERU_PSW_RESET;
			fpc_reg      <= 32'h0;
			fpsw_reg     <= 32'h0;
			epc_reg      <= 32'h0;
			epsw_reg     <= 32'h0;
			ecr_reg      <= 32'h0;
			nmi_pend_reg <= 1'b0;
			wdt_pend_reg <= 1'b0;
			lvl_reg      <= 3'h7;
			nested_reg   <= 1'b0;
			pcl_reg      <= 1'b0;
			pcv_reg      <= 32'h0;
			ack_reg      <= 1'b0;
			ack_src_reg  <= 6'h00;
		end else begin
			state_reg    <= state_next;
			psw_reg      <= psw_next;
			fpc_reg      <= fpc_next;
			fpsw_reg     <= fpsw_next;
			epc_reg      <= epc_next;
			epsw_reg     <= epsw_next;
			ecr_reg      <= ecr_next;
			nmi_pend_reg <= nmi_pend_next;
			wdt_pend_reg <= wdt_pend_next;
			lvl_reg      <= lvl_next;
			nested_reg   <= nested_next;
			pcl_reg      <= pcl_next;
			pcv_reg      <= pcv_next;
			ack_reg      <= ack_next;
			ack_src_reg  <= ack_src_next;
		end
	end

	assign pc_load          = pcl_reg;
	assign pc_value         = pcv_reg;
	assign irq_ack          = ack_reg;
	assign irq_ack_src      = ack_src_reg;
	assign cpu_status_word  = psw_reg;
	assign nmi_saved_pc     = fpc_reg;
	assign nmi_saved_status = fpsw_reg;
	assign irq_saved_pc     = epc_reg;
	assign irq_saved_status = epsw_reg;
	assign cause_code_reg   = ecr_reg;
	assign service_level    = lvl_reg;
	assign service_state    = state_reg;
endmodule
`default_nettype wire

// ---- dv/ieru_core_sva.sv ----
// Port checker for the interrupt entry and return unit.
// Assumes binding onto ieru_core; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "ieru_cfg.svh"
module ieru_chk (
	// Clock and reset
	input wire logic                     core_clk,
	input wire logic                     reset_n,
	// Pipeline side
	input wire logic [31:0]              restored_pc,
	input wire logic                     return_from_irq_op,
	input wire logic [1:0]               watchdog_mode_field,
	// Outputs watched
	input wire logic                     pc_load,
	input wire logic [31:0]              pc_value,
	input wire logic                     irq_ack,
	input wire logic [5:0]               irq_ack_src,
	input wire logic [31:0]              cpu_status_word,
	input wire logic [31:0]              nmi_saved_pc,
	input wire logic [31:0]              nmi_saved_status,
	input wire logic [31:0]              irq_saved_pc,
	input wire logic [31:0]              irq_saved_status,
	input wire logic [31:0]              cause_code_reg,
	input wire ieru_pkg::ieru_state_type service_state
);
	import ieru_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	property p_nmi_entry;
		$changed(service_state) && service_state == IERU_ST_NMI |-> pc_load
		&& pc_value == `IERU_NMI_HANDLER && cpu_status_word[7:5] == 3'b101
		&& cause_code_reg[31:16] == `IERU_NMI_CAUSE;
	endproperty
	a_nmi_entry: assert property (p_nmi_entry)
		else $error("nmi entry wrong");
	property p_nmi_save;
		$changed(service_state) && (service_state == IERU_ST_NMI
		|| service_state == IERU_ST_WDT) |-> nmi_saved_pc == $past(restored_pc)
		&& nmi_saved_status == $past(cpu_status_word);
	endproperty
	a_nmi_save: assert property (p_nmi_save)
		else $error("nmi save pair wrong");
	property p_wdt_entry;
		$changed(service_state) && service_state == IERU_ST_WDT |->
		pc_value == `IERU_WDT_HANDLER && cause_code_reg[31:16] == `IERU_NMI_CAUSE
		&& $past(watchdog_mode_field) == `IERU_WDT_NMI_MODE;
	endproperty
	a_wdt_entry: assert property (p_wdt_entry)
		else $error("watchdog entry wrong");
	property p_irq_entry;
		irq_ack |-> pc_load && pc_value == `IERU_IRQ_BASE + {22'h0, irq_ack_src, 4'h0}
		&& cause_code_reg[15:0] == `IERU_IRQ_CAUSE_BASE + {6'h0, irq_ack_src, 4'h0}
		&& cpu_status_word[6:5] == 2'b01 && irq_saved_pc == $past(restored_pc)
		&& irq_saved_status == $past(cpu_status_word);
	endproperty
	a_irq_entry: assert property (p_irq_entry)
		else $error("maskable entry wrong");
	property p_irq_gate;
		irq_ack |-> !$past(cpu_status_word[7]) && !$past(cpu_status_word[5]);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("maskable taken while blocked");
	property p_ret_nmi;
		return_from_irq_op && cpu_status_word[7:6] == 2'b10 |=> pc_load
		&& pc_value == $past(nmi_saved_pc)
		&& cpu_status_word == $past(nmi_saved_status);
	endproperty
	a_ret_nmi: assert property (p_ret_nmi)
		else $error("nmi return wrong");
	property p_ret_irq;
		return_from_irq_op && cpu_status_word[7:6] == 2'b00 |=> pc_load
		&& pc_value == $past(irq_saved_pc)
		&& cpu_status_word == $past(irq_saved_status);
	endproperty
	a_ret_irq: assert property (p_ret_irq)
		else $error("maskable return wrong");
	property p_nmi_hold;
		service_state == IERU_ST_NMI && cpu_status_word[7] && !return_from_irq_op
		|=> service_state == IERU_ST_NMI;
	endproperty
	a_nmi_hold: assert property (p_nmi_hold)
		else $error("nmi service left early");
	property p_wdt_gate;
		$changed(service_state) && service_state == IERU_ST_WDT
		|-> !$past(cpu_status_word[7]);
	endproperty
	a_wdt_gate: assert property (p_wdt_gate)
		else $error("watchdog taken while nmi active");
endmodule
`default_nettype wire

// ---- dv/ieru_far.sv ----
// Far-side model: NMI pin, watchdog request and controller levels.
// Assumes its tasks are called at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "ieru_cfg.svh"
module ieru_far (
	// Clock
	input  wire logic                     core_clk,
	// Acknowledge from the core
	input  wire logic                     irq_ack,
	input  wire logic [5:0]               irq_ack_src,
	// Far-side levels
	output logic                          nmi_pin,
	output logic                          watchdog_nmi_req,
	output logic [`IERU_NUM_SRC-1:0]      irq_req
);
	initial begin
		nmi_pin = 1'b0;
		watchdog_nmi_req = 1'b0;
		irq_req = '0;
	end
	// Request flag drops once acknowledged
	always @(posedge core_clk) begin
		if (irq_ack)
			irq_req[irq_ack_src] <= 1'b0;
	end
	task automatic raise(input int s);
		irq_req[s] = 1'b1;
	endtask
	task automatic pin(input logic v);
		nmi_pin = v;
	endtask
	// Level held a few cycles so the synchroniser sees it
	task automatic wdt;
		watchdog_nmi_req = 1'b1;
		repeat (4) @(negedge core_clk);
		watchdog_nmi_req = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- dv/test_interrupt_entry_return_unit.sv ----
// Self-checking bench for the interrupt entry and return unit.
// Assumes design files, far-side model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ieru_cfg.svh"
module test_interrupt_entry_return_unit;
	import ieru_pkg::*;
	logic        core_clk, reset_n, nmi_rise_sel, nmi_fall_sel;
	logic        return_from_irq_op, irq_unmask_op, irq_mask_op, sysreg_load_op;
	logic [1:0]  watchdog_mode_field;
	logic [2:0]  sysreg_sel;
	logic [31:0] restored_pc, sysreg_wdata, rpc, rpc2, seed;
	logic [51:0] irq_mask;
	logic [155:0] irq_prio;
	logic [31:0] exp_q[$];
	int          mismatches, checked, k, j;
	wire         nmi_pin, watchdog_nmi_req, pc_load, irq_ack;
	wire [51:0]  irq_req;
	wire [5:0]   irq_ack_src;
	wire [2:0]   service_level;
	wire [31:0]  pc_value, cpu_status_word, nmi_saved_pc, nmi_saved_status;
	wire [31:0]  irq_saved_pc, irq_saved_status, cause_code_reg;
	wire ieru_state_type service_state;
	ieru_core DUT (.*);
	ieru_far far (.*);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic check(input string n, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic summarize;
		if (mismatches == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic pulse(input logic [3:0] m);
		{sysreg_load_op, irq_mask_op, irq_unmask_op, return_from_irq_op} = m;
		wt(1);
		{sysreg_load_op, irq_mask_op, irq_unmask_op, return_from_irq_op} = 4'h0;
		wt(1);
	endtask
	task automatic load(input logic [2:0] s, input logic [31:0] d);
		sysreg_sel = s;
		sysreg_wdata = d;
		pulse(4'h8);
	endtask
	task automatic rst;
		reset_n = 1'b0;
		wt(20);
		reset_n = 1'b1;
	endtask
	// Every control transfer is matched against the oldest note
	always @(negedge core_clk) begin
		if (pc_load === 1'b1) begin
			if (exp_q.size() > 0)
				check("pc", pc_value, exp_q.pop_front());
			else
				check("pc", pc_value, 32'hffffffff);
		end
	end
	initial begin
		repeat (6000) @(posedge core_clk);
		mismatches++;
		summarize;
	end
	initial begin
		seed = 32'h309d;
		{return_from_irq_op, irq_unmask_op, irq_mask_op, sysreg_load_op} = 4'h0;
		watchdog_mode_field = 2'h1;
		rpc = $random(seed);
		rpc2 = $random(seed);
		// Idle selects and data random; pin and strobes stay quiet
		{nmi_rise_sel, nmi_fall_sel} = rpc[1:0];
		sysreg_sel = rpc2[2:0];
		sysreg_wdata = rpc ^ rpc2;
		// Sources above 9 are never raised; their levels are random, their masks only from source 20 up
		irq_mask = {rpc ^ rpc2, 20'h8};
		irq_prio = {rpc, rpc2, ~rpc, rpc2 ^ 32'h5a5a5a5a, 28'h0};
		for (k = 0; k < 10; k++)
			irq_prio[3*k+:3] = 3'h2;
		irq_prio[3+:3] = 3'h1;
		irq_prio[9+:3] = 3'h0;
		restored_pc = rpc;
		rst;
		check("status", cpu_status_word, `IERU_PSW_RESET);
		far.raise(3);
		far.raise(9);
		far.raise(5);
		wt(6);
		exp_q.push_back(32'hd0);
		pulse(4'h2);
		wt(6);
		check("cause", cause_code_reg & 32'hffff, 32'hd0);
		check("isp", irq_saved_pc, rpc);
		check("iss", irq_saved_status, 32'h0);
		check("src", {26'h0, irq_ack_src}, 32'h5);
		check("level", {29'h0, service_level}, 32'h2);
		pulse(4'h2);
		far.raise(7);
		wt(6);
		restored_pc = rpc2;
		exp_q.push_back(32'h90);
		far.raise(1);
		wt(6);
		restored_pc = rpc;
		pulse(4'h4);
		load(3'h2, `IERU_PSW_RESET);
		exp_q.push_back(rpc2);
		pulse(4'h1);
		wt(6);
		load(3'h1, rpc);
		load(3'h2, 32'h0);
		exp_q.push_back(rpc);
		exp_q.push_back(32'hf0);
		pulse(4'h1);
		wt(6);
		exp_q.push_back(rpc);
		exp_q.push_back(32'h110);
		pulse(4'h1);
		wt(6);
		exp_q.push_back(rpc);
		pulse(4'h1);
		wt(6);
		exp_q.push_back(32'hb0);
		irq_mask[3] = 1'b0;
		wt(6);
		check("level", {29'h0, service_level}, 32'h0);
		exp_q.push_back(rpc);
		pulse(4'h1);
		wt(6);
		pulse(4'h4);
		for (k = 1; k < 4; k++) begin
			{nmi_fall_sel, nmi_rise_sel} = k[1:0];
			for (j = 0; j < 2; j++) begin
				if (k[j] && !(k == 3 && j == 1))
					exp_q.push_back(`IERU_NMI_HANDLER);
				far.pin(j == 0);
				wt(8);
				if (k == 3 && j == 1) begin
					exp_q.push_back(rpc);
					exp_q.push_back(`IERU_NMI_HANDLER);
					pulse(4'h1);
					wt(8);
				end
				if (k[j] && !(k == 3 && j == 0)) begin
					exp_q.push_back(rpc);
					pulse(4'h1);
					wt(8);
				end
			end
		end
		check("npc", nmi_saved_pc, rpc);
		check("nps", nmi_saved_status, `IERU_PSW_RESET);
		check("cause", cause_code_reg >> 16, 32'h10);
		watchdog_mode_field = {rpc2[1], rpc2[1] & rpc2[0]};
		far.wdt;
		wt(8);
		watchdog_mode_field = 2'h1;
		exp_q.push_back(`IERU_NMI_HANDLER);
		far.pin(1'b1);
		wt(8);
		far.wdt;
		wt(8);
		exp_q.push_back(rpc);
		exp_q.push_back(`IERU_WDT_HANDLER);
		pulse(4'h1);
		wt(8);
		{nmi_fall_sel, nmi_rise_sel} = 2'h0;
		far.pin(1'b0);
		rst;
		{nmi_fall_sel, nmi_rise_sel} = 2'h1;
		exp_q.push_back(`IERU_NMI_HANDLER);
		far.pin(1'b1);
		wt(8);
		load(3'h0, `IERU_PSW_RESET);
		exp_q.push_back(`IERU_WDT_HANDLER);
		far.wdt;
		wt(8);
		{nmi_fall_sel, nmi_rise_sel} = 2'h0;
		far.pin(1'b0);
		rst;
		{nmi_fall_sel, nmi_rise_sel} = 2'h1;
		exp_q.push_back(`IERU_WDT_HANDLER);
		far.pin(1'b1);
		far.wdt;
		wt(8);
		// A kept pin request would show once the flag clears
		load(3'h0, `IERU_PSW_RESET);
		wt(8);
		{nmi_fall_sel, nmi_rise_sel} = 2'h0;
		far.pin(1'b0);
		rst;
		check("queue", exp_q.size(), 32'h0);
		summarize;
	end
endmodule
bind ieru_core ieru_chk u_chk (.*);
`default_nettype wire
